/* rtl/aux_bus_control.sv */
// Auxiliary bus control: address strobe, data strobes, RAM select, emulation.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module aux_bus_control
    import aux_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ale_pin_in,
    input wire logic program_store_strobe_in,
    input wire logic [9:0] xdata_addr,
    output logic ale_out,
    output logic ale_oe,
    output logic ale_weak_pullup,
    output logic program_store_strobe_weak_pullup,
    output logic program_store_strobe_float,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic expanded_ram_select,
    output logic external_select,
    output logic port_pullup_enable,
    output logic port0_float,
    output logic serial_bus_float,
    output logic onchip_emulation_mode
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RDATA = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic [2:0] ale_sync;
        logic [2:0] pss_sync;
        logic ale_low;
        logic pss_high;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic w_lane0;
        bus_state_t wstate;
        bus_state_t rstate;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] aux_pending;
        logic pending;
        logic [7:0] aux_ctrl;
        logic [4:0] cycle_ctrl;
        logic [2:0] ale_div;
        logic ale;
        logic ale_oe;
        logic emu_armed;
        logic emu;
        logic rd_n;
        logic wr_n;
        logic expanded_ram_sel;
        logic ext_sel;
        logic rd_pend;
        logic wr_pend;
        logic awready;
        logic wready;
        logic ale_pullup;
        logic port_pullup;
    } state_t;

    state_t r;
    state_t next_r;
    strobe_cmd_t strobe_cmd;
    logic strobe_active;

    strobe_timer i_strobe_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd(strobe_cmd),
        .active(strobe_active)
    );

    // Start a strobe on a new external request only when the timer is free and emulation is off.
    always_comb begin
        strobe_cmd.strobe_req = (r.rd_pend | r.wr_pend) & ~strobe_active
            & r.ext_sel & ~r.emu;
        strobe_cmd.strobe_long = r.aux_ctrl[BIT_STROBE_STRETCH];
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // One-hot codes let bvalid, arready and rvalid come straight from a state bit; awready and wready have their own flops.
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.wstate[1];
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.rstate[0];
    assign s_axi_rvalid = r.rstate[2];
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign ale_out = r.ale;
    assign ale_oe = r.ale_oe;
    assign ale_weak_pullup = r.ale_pullup;
    assign program_store_strobe_weak_pullup = r.emu;
    assign program_store_strobe_float = 1'b0;
    assign read_strobe_n = r.rd_n;
    assign write_strobe_n = r.wr_n;
    assign expanded_ram_select = r.expanded_ram_sel;
    assign external_select = r.ext_sel;
    assign port_pullup_enable = r.port_pullup;
    assign port0_float = r.emu;
    assign serial_bus_float = r.emu;
    assign onchip_emulation_mode = r.emu;

    // Size in bytes of the internal RAM picked by the size field.
    function automatic logic [10:0] expanded_ram_bytes(input logic [1:0] sz);
        expanded_ram_bytes = EXPANDED_RAM_UNIT * ({9'd0, sz} + 11'd1);
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic aw_ok;
        logic w_ok;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic wlane;
        logic [1:0] sz;
        logic [2:0] div;
        logic ext_move;
        logic in_expanded_ram;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        waddr = r.aw_addr;
        wdata = r.w_data;
        wlane = r.w_lane0;
        sz = 2'd0;
        div = 3'd0;
        ext_move = 1'b0;
        in_expanded_ram = 1'b0;
        next_r = r;

        // Pin synchronisers: a change counts when stages two and three agree.
        next_r.ale_sync = {r.ale_sync[1:0], ale_pin_in};
        next_r.pss_sync = {r.pss_sync[1:0], program_store_strobe_in};
        if (r.ale_sync[1] == r.ale_sync[2]) begin
            next_r.ale_low = ~r.ale_sync[2];
        end
        if (r.pss_sync[1] == r.pss_sync[2]) begin
            next_r.pss_high = r.pss_sync[2];
        end

        // Write address and data are taken in either order.
        aw_ok = s_axi_awvalid && s_axi_awready;
        w_ok = s_axi_wvalid && s_axi_wready;
        if (aw_ok) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
            waddr = s_axi_awaddr;
        end
        if (w_ok) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_lane0 = s_axi_wstrb[0];
            wdata = s_axi_wdata;
            wlane = s_axi_wstrb[0];
        end

        // Only whole-register writes exist; a single bit cannot be poked.
        if (r.wstate == BUS_IDLE && next_r.aw_held && next_r.w_held) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.wstate = BUS_WRESP;
            next_r.bresp = AXI_OKAY;
            if (waddr == AUX_CTRL_OFFSET) begin
                if (wlane) begin
                    // Reserved bits are dropped in case software ignores them.
                    next_r.aux_pending = wdata[7:0] & AUX_CTRL_WMASK;
                    next_r.pending = 1'b1;
                end
            end else if (waddr == CYCLE_CTRL_OFFSET) begin
                if (wlane) begin
                    next_r.cycle_ctrl = wdata[4:0];
                end
            end else if (waddr != EMU_STATUS_OFFSET) begin
                next_r.bresp = AXI_SLVERR;
            end
        end
        if (r.wstate == BUS_WRESP && s_axi_bready) begin
            next_r.wstate = BUS_IDLE;
        end

        if (r.rstate == BUS_IDLE && s_axi_arvalid) begin
            next_r.rstate = BUS_RDATA;
            next_r.rresp = AXI_OKAY;
            next_r.rdata = 32'h0;
            if (s_axi_araddr == AUX_CTRL_OFFSET) begin
                next_r.rdata = {24'h0, r.aux_ctrl};
            end else if (s_axi_araddr == EMU_STATUS_OFFSET) begin
                next_r.rdata = {28'h0, strobe_active, r.ext_sel, r.expanded_ram_sel,
                    r.emu};
            end else if (s_axi_araddr == CYCLE_CTRL_OFFSET) begin
                next_r.rdata = {27'h0, r.cycle_ctrl};
            end else begin
                next_r.rresp = AXI_SLVERR;
            end
        end
        if (r.rstate == BUS_RDATA && s_axi_rready) begin
            next_r.rstate = BUS_IDLE;
        end

        // Address strobe divider; a cycle ends at the wrap of the count.
        div = r.cycle_ctrl[BIT_DOUBLE_SPEED] ? ALE_DIV_DOUBLE : ALE_DIV_NORMAL;
        if (r.ale_div >= div - 3'd1) begin
            next_r.ale_div = 3'd0;
            // Auxiliary control changes land on an instruction cycle boundary.
            if (r.pending) begin
                next_r.aux_ctrl = r.aux_pending;
                next_r.pending = 1'b0;
            end
        end else begin
            next_r.ale_div = r.ale_div + 3'd1;
        end
        ext_move = r.cycle_ctrl[BIT_EXT_MOVE] | r.cycle_ctrl[BIT_EXT_FETCH];
        // Strobe high for the first half of each normal cycle, or the first third at double speed, latches port 0.
        next_r.ale = r.ale_div < (div / 3'd3 + 3'd0) + (div == 3'd6 ? 3'd1
            : 3'd0);
        next_r.ale_oe = ~r.aux_ctrl[BIT_ALE_SUPPRESS] | ext_move;
        if (!next_r.ale_oe) begin
            next_r.ale = 1'b1;
        end

        // Data move routing.
        sz = {r.aux_ctrl[BIT_EXPANDED_RAM_SIZE_HI], r.aux_ctrl[BIT_EXPANDED_RAM_SIZE_LO]};
        in_expanded_ram = {1'b0, xdata_addr} < expanded_ram_bytes(sz);
        next_r.ext_sel = r.cycle_ctrl[BIT_EXT_MOVE]
            & (r.aux_ctrl[BIT_EXT_DATA_SEL] | ~in_expanded_ram);
        next_r.expanded_ram_sel = r.cycle_ctrl[BIT_EXT_MOVE]
            & ~r.aux_ctrl[BIT_EXT_DATA_SEL] & in_expanded_ram;
        if (strobe_cmd.strobe_req) begin
            next_r.rd_pend = 1'b0;
            next_r.wr_pend = 1'b0;
            next_r.rd_n = ~r.rd_pend;
            next_r.wr_n = r.rd_pend | ~r.wr_pend;
        end else begin
            // A move that lands in internal RAM must not strobe later.
            next_r.rd_pend = (r.rd_pend | r.cycle_ctrl[BIT_RD_REQ])
                & ~next_r.expanded_ram_sel;
            next_r.wr_pend = (r.wr_pend | r.cycle_ctrl[BIT_WR_REQ])
                & ~next_r.expanded_ram_sel;
        end
        if (!strobe_active && !strobe_cmd.strobe_req) begin
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
        end
        // Request bits are one-shot commands.
        next_r.cycle_ctrl[BIT_RD_REQ] = 1'b0;
        next_r.cycle_ctrl[BIT_WR_REQ] = 1'b0;
        if (r.wstate == BUS_IDLE && waddr == CYCLE_CTRL_OFFSET
            && next_r.wstate == BUS_WRESP && wlane) begin
            next_r.cycle_ctrl = wdata[4:0];
        end

        // Emulation: pin levels seen while reset is held decide entry.
        // The strobe must still read low at the first edge after release.
        next_r.emu_armed = 1'b0;
        if (r.emu_armed) begin
            next_r.emu = r.ale_low;
        end
        if (next_r.emu) begin
            next_r.ale_oe = 1'b0;
            next_r.ale = 1'b1;
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
        end
        // Flopped copies keep the pins free of decode glitches.
        next_r.ale_pullup = ~next_r.ale_oe;
        next_r.port_pullup = ~next_r.aux_ctrl[BIT_PULLUP_DISABLE]
            | next_r.emu;
        next_r.awready = next_r.wstate == BUS_IDLE && !next_r.aw_held;
        next_r.wready = next_r.wstate == BUS_IDLE && !next_r.w_held;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.wstate <= BUS_IDLE;
            r.rstate <= BUS_IDLE;
            r.aux_ctrl <= AUX_CTRL_RESET;
            r.aux_pending <= AUX_CTRL_RESET;
            r.ale_sync <= 3'b111;
            r.pss_sync <= 3'b111;
            r.ale <= 1'b1;
            r.ale_oe <= 1'b1;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
            r.pss_high <= 1'b1;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.port_pullup <= ~AUX_CTRL_RESET[BIT_PULLUP_DISABLE];
            // Entry is armed while reset holds with the pins as required.
            r.emu_armed <= r.ale_low & r.pss_high;
            r.ale_low <= r.ale_sync[1] == r.ale_sync[2] ? ~r.ale_sync[2]
                : r.ale_low;
            r.pss_high <= r.pss_sync[1] == r.pss_sync[2] ? r.pss_sync[2]
                : r.pss_high;
            r.ale_sync <= {r.ale_sync[1:0], ale_pin_in};
            r.pss_sync <= {r.pss_sync[1:0], program_store_strobe_in};
            r.emu <= 1'b0;
        end else begin
            r <= next_r;
        end
    end
endmodule

/* shared/aux_ctrl_pkg.sv */
// Package with register map, field layout and timing of the auxiliary control.
package aux_ctrl_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] AUX_CTRL_OFFSET = 8'h8E;
    localparam logic [7:0] AUX_CTRL_RESET = 8'h0C;
    localparam logic [7:0] AUX_CTRL_WMASK = 8'hAF;
    localparam logic [7:0] EMU_STATUS_OFFSET = 8'h90;
    localparam logic [7:0] CYCLE_CTRL_OFFSET = 8'h94;
    localparam int BIT_ALE_SUPPRESS = 0;
    localparam int BIT_EXT_DATA_SEL = 1;
    localparam int BIT_EXPANDED_RAM_SIZE_LO = 2;
    localparam int BIT_EXPANDED_RAM_SIZE_HI = 3;
    localparam int BIT_STROBE_STRETCH = 5;
    localparam int BIT_PULLUP_DISABLE = 7;
    localparam int BIT_DOUBLE_SPEED = 0;
    localparam int BIT_EXT_MOVE = 1;
    localparam int BIT_EXT_FETCH = 2;
    localparam int BIT_RD_REQ = 3;
    localparam int BIT_WR_REQ = 4;
    // ---------------------------------------------------------------
    // Timing in oscillator (clock) periods, bus response codes and RAM size unit
    // ---------------------------------------------------------------
    localparam logic [4:0] STROBE_SHORT = 5'd6;
    localparam logic [4:0] STROBE_LONG = 5'd30;
    localparam logic [2:0] ALE_DIV_NORMAL = 3'd6;
    localparam logic [2:0] ALE_DIV_DOUBLE = 3'd3;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    localparam logic [10:0] EXPANDED_RAM_UNIT = 11'd256;

    typedef struct packed {
        logic strobe_req;
        logic strobe_long;
    } strobe_cmd_t;
endpackage

/* rtl/strobe_timer.sv */
// Pulse generator for the external read and write strobes.
`timescale 1ns/1ps
module strobe_timer
    import aux_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire strobe_cmd_t cmd,
    output logic active
);
    typedef struct packed {
        logic [4:0] count;
        logic active;
    } timer_state_t;

    timer_state_t r;
    timer_state_t next_r;

    assign active = r.active;

    always_comb begin
        next_r = r;
        if (r.active) begin
            next_r.count = r.count - 5'd1;
            if (r.count == 5'd1) begin
                next_r.active = 1'b0;
            end
        end else if (cmd.strobe_req) begin
            next_r.active = 1'b1;
            // The pin flop downstream adds one cycle, so count one less.
            next_r.count = (cmd.strobe_long ? STROBE_LONG : STROBE_SHORT)
                - 5'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule

/* bench/aux_bus_control_asserts.sv */
// Port checker for the auxiliary bus control block.
`timescale 1ns/1ps
module aux_bus_control_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic ale_oe,
    input wire logic ale_weak_pullup,
    input wire logic program_store_strobe_weak_pullup,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic expanded_ram_select,
    input wire logic external_select,
    input wire logic port0_float,
    input wire logic serial_bus_float,
    input wire logic onchip_emulation_mode
);
    logic [5:0] low_len;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ---------------------------------------------------------------
    // Strobe length counter
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || (read_strobe_n && write_strobe_n)) begin
            low_len <= 6'h00;
        end else begin
            low_len <= low_len + 6'h01;
        end
    end
    a_pullup_inverse: assert property (ale_weak_pullup == !ale_oe)
        else $error("address strobe pull-up not opposite to drive");
    a_emu_pins: assert property (onchip_emulation_mode |->
        ale_weak_pullup && program_store_strobe_weak_pullup
        && port0_float && serial_bus_float)
        else $error("pin states wrong in emulation");
    a_emu_sticky: assert property (onchip_emulation_mode
        |=> onchip_emulation_mode)
        else $error("emulation left without reset");
    a_emu_entry: assert property ($rose(onchip_emulation_mode) |->
        !($past(aresetn, 1) && $past(aresetn, 2) && $past(aresetn, 3)))
        else $error("emulation entered outside reset");
    a_route_onehot: assert property (!(expanded_ram_select && external_select))
        else $error("both memory routes selected");
    a_strobe_length: assert property (
        $rose(read_strobe_n && write_strobe_n)
        |-> (low_len == 6'h06 || low_len == 6'h1E))
        else $error("data strobe length neither 6 nor 30");
    a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
        else $error("read and write strobes together");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule
bind aux_bus_control aux_bus_control_asserts i_aux_bus_control_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .ale_oe(ale_oe),
    .ale_weak_pullup(ale_weak_pullup),
    .program_store_strobe_weak_pullup(program_store_strobe_weak_pullup),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .expanded_ram_select(expanded_ram_select), .external_select(external_select),
    .port0_float(port0_float), .serial_bus_float(serial_bus_float),
    .onchip_emulation_mode(onchip_emulation_mode));

/* bench/ext_party_model.sv */
// External memory and emulator model on the far side of the pins.
`timescale 1ns/1ps
module ext_party_model (
    input wire logic ale_out,
    input wire logic ale_oe,
    input wire logic emu_hold_low,
    input wire logic [9:0] xdata_addr,
    output logic ale_pin,
    output logic program_store_strobe_pin,
    output logic [7:0] latched_addr
);
    // The emulator overpowers the pin; a released pin floats to the pull-up.
    assign ale_pin = emu_hold_low ? 1'b0
        : (ale_oe ? ale_out : 1'b1);
    assign program_store_strobe_pin = 1'b1;
    always @(negedge ale_pin) begin
        latched_addr <= xdata_addr[7:0];
    end
endmodule

/* bench/test_aux_bus_control.sv */
// Self-checking bench for the auxiliary bus control block.
`timescale 1ns/1ps
module test_aux_bus_control import aux_ctrl_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, emu_hold_low = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ale_pin_in, program_store_strobe_in, ale_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] xdata_addr = 10'h000;
    logic ale_oe, ale_weak_pullup, program_store_strobe_weak_pullup;
    logic program_store_strobe_float, read_strobe_n, write_strobe_n;
    logic expanded_ram_select, external_select, port_pullup_enable, port0_float;
    logic serial_bus_float, onchip_emulation_mode;
    logic [33:0] b_q[$], r_q[$], len_q[$], low_n = 34'h0, n_oe, n_lo;
    logic [31:0] seed = 32'h00000943;
    logic [7:0] latched;
    int err_count = 0, checked = 0, sz;
    aux_bus_control i_aux_bus_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ale_pin_in(ale_pin_in),
        .program_store_strobe_in(program_store_strobe_in),
        .xdata_addr(xdata_addr), .ale_out(ale_out), .ale_oe(ale_oe),
        .ale_weak_pullup(ale_weak_pullup),
        .program_store_strobe_weak_pullup(program_store_strobe_weak_pullup),
        .program_store_strobe_float(program_store_strobe_float),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .expanded_ram_select(expanded_ram_select), .external_select(external_select),
        .port_pullup_enable(port_pullup_enable), .port0_float(port0_float),
        .serial_bus_float(serial_bus_float),
        .onchip_emulation_mode(onchip_emulation_mode));
    ext_party_model i_ext_party_model (.ale_out(ale_out), .ale_oe(ale_oe),
        .emu_hold_low(emu_hold_low), .xdata_addr(xdata_addr),
        .ale_pin(ale_pin_in), .program_store_strobe_pin(program_store_strobe_in),
        .latched_addr(latched));
    always #50 aclk = ~aclk;
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic close_out();
        if (err_count == 0 && checked != 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] e,
            input logic [33:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // The request is held until the edge that takes it, then released.
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        b_q.push_back({32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        logic ta, tr;
        tr = 1'b0;
        r_q.push_back({AXI_OKAY, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic rst(input logic emu);
        @(posedge aclk);
        emu_hold_low <= emu;
        aresetn <= 1'b0;
        // Entry needs the low pin through the synchroniser before release.
        repeat (emu ? 8 : 4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        emu_hold_low <= 1'b0;
    endtask
    task automatic oe_count();
        n_oe = 34'h0;
        n_lo = 34'h0;
        repeat (12) begin
            @(negedge aclk);
            n_oe += {33'h0, ale_oe === 1'b1};
            n_lo += {33'h0, ale_pin_in !== 1'b1};
        end
    endtask
    task automatic ale_period(input logic [33:0] e);
        logic [33:0] n;
        do @(negedge aclk); while (ale_out !== 1'b0);
        do @(negedge aclk); while (ale_out !== 1'b1);
        n = 34'h0;
        do begin @(negedge aclk); n++; end while (ale_out !== 1'b0);
        do begin @(negedge aclk); n++; end while (ale_out !== 1'b1);
        chk("ale_period", e, n);
    endtask
    task automatic access(input logic rd_kind, input logic to_expanded_ram);
        repeat (7) @(posedge aclk);
        if (!to_expanded_ram) len_q.push_back(s_axi_wdata[5] ? 34'd30 : 34'd6);
        wr(CYCLE_CTRL_OFFSET, rd_kind ? 8'h0A : 8'h12, AXI_OKAY);
        for (int t = 0; t < 8 && !(expanded_ram_select || external_select); t++)
            @(negedge aclk);
        chk("expanded_ram_select", {33'h0, to_expanded_ram}, {33'h0, expanded_ram_select});
        chk("latched_addr", {26'h0, xdata_addr[7:0]}, {26'h0, latched});
        repeat (40) @(posedge aclk);
        wr(CYCLE_CTRL_OFFSET, 8'h00, AXI_OKAY);
    endtask
    // ---------------------------------------------------------------
    // Result monitor and watchdog
    // ---------------------------------------------------------------
    always @(negedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", b_q.pop_front(), {32'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", r_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (!read_strobe_n || !write_strobe_n) begin
            low_n++;
        end else if (low_n != 34'h0) begin
            chk("strobe_len", len_q.pop_front(), low_n);
            low_n = 34'h0;
        end
    end
    initial begin
        #3000000;
        err_count++;
        close_out();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst(1'b0);
        rd(AUX_CTRL_OFFSET, 32'h0000000C);
        wr(8'h44, 8'h01, AXI_SLVERR);
        wr(AUX_CTRL_OFFSET, 8'hAF, AXI_OKAY);
        repeat (6) @(posedge aclk);
        rd(AUX_CTRL_OFFSET, 32'h000000AF);
        repeat (8) @(negedge aclk);
        chk("pullups", 34'h0, {33'h0, port_pullup_enable});
        oe_count();
        chk("ale_quiet", 34'h0, n_oe);
        chk("ale_pin_high", 34'h0, n_lo);
        wr(CYCLE_CTRL_OFFSET, 8'h04, AXI_OKAY);
        repeat (7) @(posedge aclk);
        oe_count();
        chk("ale_fetch", 34'h1, {33'h0, n_oe != 34'h0});
        wr(CYCLE_CTRL_OFFSET, 8'h00, AXI_OKAY);
        wr(AUX_CTRL_OFFSET, 8'h0C, AXI_OKAY);
        repeat (8) @(negedge aclk);
        chk("pullups", 34'h1, {33'h0, port_pullup_enable});
        ale_period(34'd6);
        wr(CYCLE_CTRL_OFFSET, 8'h01, AXI_OKAY);
        ale_period(34'd3);
        wr(CYCLE_CTRL_OFFSET, 8'h00, AXI_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(AUX_CTRL_OFFSET, i[0] ? 8'h2E : 8'h0E, AXI_OKAY);
            access(i[1], 1'b0);
        end
        for (int s = 0; s < 3; s++) begin
            wr(AUX_CTRL_OFFSET, 8'(s << 2), AXI_OKAY);
            sz = 256 * (s + 1);
            for (int k = 0; k < 2; k++) begin
                seed = xs(seed);
                xdata_addr <= k ? 10'(sz + seed % (1024 - sz)) : 10'(seed % sz);
                access(1'b1, k == 0);
            end
        end
        rst(1'b1);
        chk("emulation", 34'h1, {33'h0, onchip_emulation_mode});
        chk("port0_float", 34'h1, {33'h0, port0_float});
        chk("ale_pullup", 34'h1, {33'h0, ale_weak_pullup});
        rst(1'b0);
        chk("emulation", 34'h0, {33'h0, onchip_emulation_mode});
        close_out();
    end
endmodule
